// ---- core/reset_and_clock_out_sequencer.sv ----
/*
 * Reset and programmable clock-output sequencer.
 * Assumes mclk_i is the reference clock and power-on and hardware
 * reset requests arrive synchronous to it.
 */
`timescale 1ns/1ps

// Summary of operation
// - Power-on reloads registers, restarts clock generator
// - Power-on stalls clock output 2^14 cycles
// - No register access during the stall
// - Any reset disables transceiver regulator output
// - Setup register gates and divides clock output
// - After reset clock output runs at 4 MHz
// - DLL variant: hardware reset also stalls output
// - Active-low hardware reset reverts all registers
// - DLL variant: hardware reset equals power-on
module reset_and_clock_out_sequencer #(
    parameter bit HAS_DLL = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic power_on_i,
    input wire logic hw_reset_n_i,
    input wire logic setup_wr_i,
    input wire rst_seq_pkg::clock_setup_t setup_wdata_i,
    input wire logic reg_enable_wr_i,
    input wire logic reg_enable_wdata_i,
    output logic prog_clock_output_o,
    output logic access_enable_o,
    output logic reg_enable_o,
    output logic gen_restart_o,
    output rst_seq_pkg::clock_setup_t clock_setup_register_o
);

    ////////////////////////////////////////////////////////////////////////
    // Reset sources
    logic any_reset;
    logic stall_reset;
    assign any_reset = rst_i || power_on_i || !hw_reset_n_i;
    assign stall_reset = rst_i || power_on_i || (HAS_DLL && !hw_reset_n_i);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    rst_seq_pkg::seq_state_t state_reg, state_next;
    logic [rst_seq_pkg::STALL_W-1:0] cnt_reg, cnt_next;
    logic access_reg, access_next;
    logic restart_reg, restart_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        access_next = access_reg;
        restart_next = 1'b0;
        if (stall_reset) begin
            state_next = rst_seq_pkg::ST_RESET;
            cnt_next = '0;
            access_next = 1'b0;
            restart_next = 1'b1;
        end else begin
            case (state_reg)
                rst_seq_pkg::ST_RESET: begin
                    state_next = rst_seq_pkg::ST_STALL;
                    cnt_next = '0;
                end
                rst_seq_pkg::ST_STALL: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == rst_seq_pkg::STALL_W'(rst_seq_pkg::STALL_CYCLES - 1)) begin
                        state_next = rst_seq_pkg::ST_RUN;
                        access_next = 1'b1;
                    end
                end
                default: begin
                    state_next = rst_seq_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        access_reg <= access_next;
        restart_reg <= restart_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Setup register and regulator enable
    rst_seq_pkg::clock_setup_t setup_reg, setup_next;
    logic regen_reg, regen_next;

    always_comb begin
        setup_next = setup_reg;
        regen_next = regen_reg;
        if (any_reset) begin
            setup_next.clk_enable = rst_seq_pkg::CLK_EN_RESET;
            setup_next.clk_div = rst_seq_pkg::DIV_RESET;
            setup_next.reg_enable = rst_seq_pkg::REG_EN_RESET;
            regen_next = rst_seq_pkg::REG_EN_RESET;
        end else if (access_reg) begin
            if (setup_wr_i) begin
                setup_next = setup_wdata_i;
            end
            if (reg_enable_wr_i) begin
                regen_next = reg_enable_wdata_i;
            end
        end
        setup_next.reg_enable = regen_next;
    end

    always_ff @(posedge mclk_i) begin
        setup_reg <= setup_next;
        regen_reg <= regen_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock output divider
    logic [rst_seq_pkg::DIV_W-1:0] div_cnt_reg, div_cnt_next;
    logic clk_out_reg, clk_out_next;

    always_comb begin
        div_cnt_next = div_cnt_reg;
        clk_out_next = clk_out_reg;
        if (stall_reset || !access_reg || !setup_reg.clk_enable) begin
            div_cnt_next = '0;
            clk_out_next = 1'b0;
        end else if (div_cnt_reg >= setup_reg.clk_div) begin
            div_cnt_next = '0;
            clk_out_next = !clk_out_reg;
        end else begin
            div_cnt_next = div_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        div_cnt_reg <= div_cnt_next;
        clk_out_reg <= clk_out_next;
    end

    assign prog_clock_output_o = clk_out_reg;
    assign access_enable_o = access_reg;
    assign reg_enable_o = regen_reg;
    assign gen_restart_o = restart_reg;
    assign clock_setup_register_o = setup_reg;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    localparam logic [rst_seq_pkg::STALL_W-1:0] STALL_LAST =
        rst_seq_pkg::STALL_W'(rst_seq_pkg::STALL_CYCLES - 1);

    if (rst_seq_pkg::STALL_LOG2 < 1 || rst_seq_pkg::STALL_W <= rst_seq_pkg::STALL_LOG2) begin : g_bad_stall
        $error("stall counter cannot hold the stall length");
    end
    if (rst_seq_pkg::DIV_W != $bits(rst_seq_pkg::DIV_RESET)) begin : g_bad_div
        $error("divide counter width differs from setup field");
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    // Reset and restart
    a_restart_pulse: assert property (@(posedge mclk_i)
        stall_reset |=> gen_restart_o)
        else $error("generator restart missing");
    a_restart_quiet: assert property (@(posedge mclk_i)
        !stall_reset |=> !gen_restart_o)
        else $error("generator restart without reset");
    a_regulator_off: assert property (@(posedge mclk_i)
        any_reset |=> !reg_enable_o)
        else $error("regulator enabled after reset");
    a_default_div: assert property (@(posedge mclk_i)
        any_reset |=> clock_setup_register_o.clk_div == rst_seq_pkg::DIV_RESET)
        else $error("clock divide not restored");
    a_hw_rst_regs: assert property (@(posedge mclk_i)
        !hw_reset_n_i |=> clock_setup_register_o.clk_enable)
        else $error("hardware reset left setup");
    a_dll_same: assert property (@(posedge mclk_i)
        (HAS_DLL && !hw_reset_n_i) |=> gen_restart_o)
        else $error("hardware reset not like power-on");

    // Stall and access
    a_stall_holds_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_reg == rst_seq_pkg::ST_STALL) |-> !prog_clock_output_o)
        else $error("clock output toggled during stall");
    a_out_zero_reset: assert property (@(posedge mclk_i)
        stall_reset |=> !prog_clock_output_o)
        else $error("clock output running in reset");
    a_no_access_stall: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_reg != rst_seq_pkg::ST_RUN) |-> !access_enable_o)
        else $error("access enabled during stall");
    a_access_reset: assert property (@(posedge mclk_i)
        stall_reset |=> !access_enable_o)
        else $error("access left enabled by reset");
    a_stall_stays: assert property (@(posedge mclk_i) disable iff (stall_reset)
        (state_reg == rst_seq_pkg::ST_STALL && cnt_reg != STALL_LAST) |=>
        (state_reg == rst_seq_pkg::ST_STALL && !access_enable_o))
        else $error("stall ended early");
    a_stall_ends: assert property (@(posedge mclk_i) disable iff (stall_reset)
        (state_reg == rst_seq_pkg::ST_STALL && cnt_reg == STALL_LAST) |=> access_enable_o)
        else $error("stall did not end at terminal count");
    a_run_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_reg == rst_seq_pkg::ST_RUN && !stall_reset) |=> access_enable_o)
        else $error("access dropped while running");
    a_hw_rst_stall: assert property (@(posedge mclk_i)
        (HAS_DLL && !hw_reset_n_i) |=> !access_enable_o)
        else $error("hardware reset did not stall");
    a_nodll_keeps: assert property (@(posedge mclk_i) disable iff (rst_i || power_on_i)
        (!HAS_DLL && access_enable_o) |=> access_enable_o)
        else $error("hardware reset stalled without dll");

    // Setup writes
    a_refused_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!access_enable_o && !any_reset) |=> $stable(clock_setup_register_o))
        else $error("setup changed while access blocked");
    a_write_taken: assert property (@(posedge mclk_i) disable iff (rst_i)
        (access_enable_o && !any_reset && setup_wr_i) |=>
        (clock_setup_register_o.clk_div == $past(setup_wdata_i.clk_div) &&
        clock_setup_register_o.clk_enable == $past(setup_wdata_i.clk_enable)))
        else $error("setup write not taken");
    a_reg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        (access_enable_o && !any_reset && reg_enable_wr_i) |=>
        (reg_enable_o == $past(reg_enable_wdata_i)))
        else $error("regulator write not taken");
    a_clk_disable: assert property (@(posedge mclk_i) disable iff (any_reset)
        !clock_setup_register_o.clk_enable |=> !prog_clock_output_o)
        else $error("disabled clock output toggled");

endmodule // reset_and_clock_out_sequencer

// ---- core/rst_seq_pkg.sv ----
/*
 * Constants and carrier types for the reset and clock-output sequencer.
 * Assumes a single system clock; no software-visible register bus.
 */
package rst_seq_pkg;
    localparam int REF_FREQ_HZ = 24000000;
    localparam int STALL_LOG2 = 14;
    localparam int STALL_CYCLES = 1 << STALL_LOG2;
    localparam int STALL_W = STALL_LOG2 + 1;
    // Divide field: output period = 2*(div+1) reference cycles
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET = 4'h2;
    localparam logic CLK_EN_RESET = 1'b1;
    localparam logic REG_EN_RESET = 1'b0;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_STALL = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic clk_enable;
        logic [3:0] clk_div;
        logic reg_enable;
    } clock_setup_t;
endpackage

// ---- sim/reset_and_clock_out_sequencer_test.sv ----
/* Bench for the reset and clock-output sequencer.
   Assumes the package stall count of 2^14 and the DLL variant. */
`timescale 1ns/1ps
module reset_and_clock_out_sequencer_test;
logic mclk_i = 0, rst_i = 1, power_on_i = 0, hw_reset_n_i = 1, hi;
logic setup_wr_i = 0, reg_enable_wr_i = 0, reg_enable_wdata_i = 0;
logic prog_clock_output_o, access_enable_o, reg_enable_o, gen_restart_o;
logic access_nodll, restart_nodll;
rst_seq_pkg::clock_setup_t setup_wdata_i = '0, clock_setup_register_o, d;
int n_fail = 0, tests_run = 0, seed = 32'h2efd, c, k;
string nm_q[$];
logic [15:0] exp_q[$], seen_q[$];
localparam logic [15:0] SETUP_RST = 16'({rst_seq_pkg::CLK_EN_RESET, rst_seq_pkg::DIV_RESET});
wire logic [15:0] seen_setup = 16'({clock_setup_register_o.clk_enable,
    clock_setup_register_o.clk_div});
reset_and_clock_out_sequencer reset_and_clock_out_sequencer_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .power_on_i(power_on_i), .hw_reset_n_i(hw_reset_n_i),
    .setup_wr_i(setup_wr_i), .setup_wdata_i(setup_wdata_i),
    .reg_enable_wr_i(reg_enable_wr_i), .reg_enable_wdata_i(reg_enable_wdata_i),
    .prog_clock_output_o(prog_clock_output_o), .access_enable_o(access_enable_o),
    .reg_enable_o(reg_enable_o), .gen_restart_o(gen_restart_o),
    .clock_setup_register_o(clock_setup_register_o));
reset_and_clock_out_sequencer #(.HAS_DLL(1'b0)) reset_and_clock_out_sequencer_nodll_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .power_on_i(power_on_i), .hw_reset_n_i(hw_reset_n_i),
    .setup_wr_i(setup_wr_i), .setup_wdata_i(setup_wdata_i),
    .reg_enable_wr_i(reg_enable_wr_i), .reg_enable_wdata_i(reg_enable_wdata_i),
    .prog_clock_output_o(), .access_enable_o(access_nodll),
    .reg_enable_o(), .gen_restart_o(restart_nodll),
    .clock_setup_register_o());
initial forever #2.5 mclk_i = ~mclk_i;
////////////////////////////////////////////////////////////////////////////////
task finish_test;
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task note(input string nm, input logic [15:0] e, input logic [15:0] s);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    seen_q.push_back(s);
endtask
always @(posedge mclk_i) begin
    while (seen_q.size() > 0) begin
        tests_run++;
        if (seen_q[0] !== exp_q[0]) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm_q[0], exp_q[0], seen_q[0]);
        end
        void'(nm_q.pop_front());
        void'(exp_q.pop_front());
        void'(seen_q.pop_front());
    end
end
////////////////////////////////////////////////////////////////////////////////
task edge_to(input bit acc, input logic lv, inout int n);
    do begin
        @(posedge mclk_i);
        #1;
        n++;
    end while ((acc ? access_enable_o : prog_clock_output_o) !== lv && n < 20000);
    if (n >= 20000) begin
        n_fail++;
        finish_test;
    end
endtask
task wr(input rst_seq_pkg::clock_setup_t v, input logic r);
    @(posedge mclk_i);
    setup_wr_i <= 1'b1;
    setup_wdata_i <= v;
    reg_enable_wr_i <= 1'b1;
    reg_enable_wdata_i <= r;
    @(posedge mclk_i);
    setup_wr_i <= 1'b0;
    reg_enable_wr_i <= 1'b0;
    #1;
endtask
task period(input int e, input string nm);
    k = 0;
    edge_to(0, 1'b0, k);
    edge_to(0, 1'b1, k);
    c = 0;
    edge_to(0, 1'b0, c);
    edge_to(0, 1'b1, c);
    note(nm, 16'(e), 16'(c));
endtask
task stall(input int which, input int len);
    @(posedge mclk_i);
    case (which)
        0: rst_i <= 1'b1;
        1: power_on_i <= 1'b1;
        default: hw_reset_n_i <= 1'b0;
    endcase
    repeat (len) @(posedge mclk_i);
    rst_i <= 1'b0;
    power_on_i <= 1'b0;
    hw_reset_n_i <= 1'b1;
    #1;
    note("restart", 16'h0001, 16'(gen_restart_o));
    note("regulator", 16'h0000, 16'(reg_enable_o));
    note("setup", SETUP_RST, seen_setup);
    note("clock out", 16'h0000, 16'(prog_clock_output_o));
    note("access", 16'h0000, 16'(access_enable_o));
    if (which == 2) begin
        note("access without dll", 16'h0001, 16'(access_nodll));
        note("restart without dll", 16'h0000, 16'(restart_nodll));
    end
    wr('1, 1'b1);
    c = 2;
    edge_to(1, 1'b1, c);
    note("stall", 16'(rst_seq_pkg::STALL_CYCLES + 1), 16'(c));
    note("refused setup", SETUP_RST, seen_setup);
    note("refused regulator", 16'h0000, 16'(reg_enable_o));
    period(6, "reset rate");
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    stall(0, 11);
    for (int i = 0; i < 4; i++) begin
        d = 6'($random(seed));
        d.clk_enable = 1'b1;
        wr(d, 1'b1);
        note("regulator", 16'h0001, 16'(reg_enable_o));
        note("setup", 16'({1'b1, d.clk_div}), seen_setup);
        note("mirror", 16'h0001, 16'(clock_setup_register_o.reg_enable));
        period(2 * (d.clk_div + 1), "rate");
    end
    d.clk_enable = 1'b0;
    wr(d, 1'b1);
    hi = 1'b0;
    repeat (2) @(posedge mclk_i);
    repeat (40) begin
        @(posedge mclk_i);
        #1;
        hi = hi | prog_clock_output_o;
    end
    note("disabled", 16'h0000, 16'(hi));
    stall(1, 1);
    wr(d, 1'b1);
    stall(2, 1);
    @(posedge mclk_i);
    #1;
    finish_test;
end
endmodule // reset_and_clock_out_sequencer_test
